// >>> common/volume_step_defines.vh
/*
 * Timing counts, step range and default steps of the volume step control.
 * Included by the volume step control design file under src/; holds definitions only.
 */
`ifndef VOLUME_STEP_DEFINES_VH
`define VOLUME_STEP_DEFINES_VH

`define VOL_EXT_DIV 2
`define VOL_FIRST_HOLD 8'd4
`define VOL_REP1 8'd40
`define VOL_REP2 8'd20
`define VOL_REP3 8'd12
`define VOL_REP4 8'd8
`define VOL_REP_LAST 8'd4
`define VOL_STEP_W 6
`define VOL_STEP_MAX 6'h3f
`define VOL_STEP_MIN 6'h00
`define VOL_DEF_BRIDGED 6'h3a
`define VOL_DEF_SINGLE 6'h34

`endif

// >>> sim/vol_keys.sv
/* Controller model pressing the raise and lower keys.
Assumes clk is the block clock. */
`timescale 1ns/100ps
`default_nettype none
module vol_keys(input wire logic clk,output logic vol_up=0,output logic vol_down=0);
// Keys swing fully, so only 0 or 1 ever reaches the pins.
task automatic press(input logic u,d);
	@(posedge clk);
	vol_up<=u;
	vol_down<=d;
endtask
endmodule // vol_keys
`default_nettype wire

// >>> sim/volume_step_repeat_control_tb.sv
/* Bench for the volume step block.
Assumes the oscillator tick may pulse every second clock. */
`timescale 1ns/100ps
`default_nettype none
`define CHK(a,b) begin checks_done++; if((a)!==(b)) begin n_fail++; $display("wrong value at %0t: got %0h expected %0h",$time,a,b); end end
module volume_step_repeat_control_tb;
logic clk=0,rst_n=0,osc_tick=0,main_present=1,bridged_load_mode=1,step_pulse;
logic [5:0] vol_step;
logic ext_clk_sel=0,ext_clk_in=0;
wire logic vol_up,vol_down;
int n_fail=0,checks_done=0,cnt=0,got[$];
vol_keys keys(.*);
volume_step_repeat_control uut(.*,.aux_present(1'b1));
initial forever #50 clk=~clk;
// Ticks seen with one key held are counted between steps.
always @(posedge clk) begin
	osc_tick<=~osc_tick;
	if(step_pulse) begin got.push_back(cnt); cnt=osc_tick&&(vol_up^vol_down); end
	else if(!(vol_up^vol_down)) cnt=0;
	else if(osc_tick) cnt++;
end
task automatic hold(input logic u,d,input int n);
	got={};
	keys.press(u,d);
	repeat(n) @(posedge clk);
	keys.press(0,0);
	repeat(3) @(posedge clk);
endtask
task automatic t_load(input logic b,input logic [5:0] v);
	@(posedge clk) rst_n<=0;
	bridged_load_mode<=b;
	repeat(6) @(posedge clk);
	rst_n<=1;
	repeat(2) @(posedge clk);
	`CHK(vol_step,v)
	$display("load end");
endtask
task automatic t_ramp;
	int e[6]='{4,40,20,12,8,4};
	hold(0,1,182);
	foreach(e[i]) `CHK(got[i],e[i])
	hold(1,0,9);
	`CHK(got[0],4)
	`CHK(vol_step,6'h35)
	$display("ramp end");
endtask
task automatic t_block;
	hold(1,1,100);
	`CHK(vol_step,6'h35)
	@(posedge clk) main_present<=0;
	hold(1,0,60);
	main_present<=1;
	`CHK(vol_step,6'h35)
	$display("block end");
endtask
task automatic t_ends;
	hold(1,0,400);
	`CHK(vol_step,6'h3f)
	hold(0,1,700);
	`CHK(vol_step,6'h00)
	$display("ends end");
endtask
// One external period of 120 clocks is 12 us, under the 100 kHz ceiling.
task automatic ext_pulse;
	repeat(60) @(posedge clk);
	ext_clk_in<=1;
	repeat(60) @(posedge clk);
	ext_clk_in<=0;
endtask
task automatic t_ext;
	ext_clk_sel<=1;
	keys.press(1,0);
	repeat(7) ext_pulse;
	repeat(4) @(posedge clk);
	`CHK(vol_step,6'h34)
	ext_pulse;
	repeat(4) @(posedge clk);
	`CHK(vol_step,6'h35)
	keys.press(0,0);
	ext_clk_sel<=0;
	$display("ext end");
endtask
task automatic results;
	$display("fails %0d checks %0d",n_fail,checks_done);
	if(n_fail==0&&checks_done>0) $display("[ PASS ]");
	else $display("[ FAIL ]");
	$finish;
endtask
initial begin #400000; n_fail++; results; end
initial begin t_load(1,6'h3a); t_ramp; t_block; t_ends; t_load(0,6'h34); t_ext; results; end
endmodule // volume_step_repeat_control_tb
`default_nettype wire

// >>> sim/vsr_props.sv
/* Port checker for the volume step block.
Assumes rst_n is released on a clock edge. */
`timescale 1ns/100ps
`default_nettype none
module vsr_props(input wire logic clk,rst_n,vol_up,vol_down,main_present,bridged_load_mode,step_pulse,
	input wire logic [5:0] vol_step);
default clocking @(posedge clk); endclocking
default disable iff (!rst_n);
pulse_one_a: assert property (step_pulse|=>!step_pulse) else $error("pulse");
restart_a: assert property (!vol_up&&!vol_down|=>!step_pulse[*4]) else $error("early");
both_a: assert property (vol_up&&vol_down|=>!step_pulse) else $error("both");
frozen_a: assert property ($past(rst_n&&!main_present)&&!main_present|=>$stable(vol_step)) else $error("hold");
load_a: assert property (!$past(rst_n)|=>vol_step==($past(bridged_load_mode)?6'h3a:6'h34)) else $error("load");
step_a: assert property (step_pulse|->vol_step==$past(vol_step)+($past(vol_up)?6'h01:6'h3f)) else $error("step");
top_a: assert property (vol_step==6'h3f&&!vol_down&&$past(!vol_down)|=>vol_step==6'h3f) else $error("top");
bottom_a: assert property (vol_step==6'h00&&!vol_up&&$past(!vol_up&&rst_n)|=>vol_step==6'h00) else $error("low");
cover property (step_pulse&&vol_down);
cover property (vol_up&&vol_down);
cover property (!main_present&&vol_up);
endmodule // vsr_props
bind volume_step_repeat_control vsr_props chk(.*);
`default_nettype wire

// >>> src/tick_divider.v
/*
 * Divides an enable rate by a fixed ratio into one-cycle pulses.
 * Assumes the input enable is synchronous to clk.
 */
`timescale 1ns/100ps
`default_nettype none
module tick_divider #(
	parameter integer DIV = 2
) (
	input wire clk, // system clock
	input wire rst_n, // asynchronous reset, active low
	input wire en_in, // enable pulse to divide
	output reg tick // one pulse per DIV input pulses
);
	reg [7:0] cnt_q;

	always @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			cnt_q <= 8'h00;
			tick <= 1'b0;
		end else begin
			tick <= 1'b0;
			if (en_in) begin
				if (cnt_q == DIV[7:0] - 8'h01) begin
					cnt_q <= 8'h00;
					tick <= 1'b1;
				end else begin
					cnt_q <= cnt_q + 8'h01;
				end
			end
		end
	end
endmodule // tick_divider
`default_nettype wire

// >>> src/volume_step_repeat_control.v
/*
 * Volume step control with hold-to-repeat acceleration and retained setting.
 * Assumes raise/lower and the external clock level are synchronous to clk;
 * rst_n is the power-up reset after main and auxiliary supply are both lost.
 */
// Function
// R1 - External clock is halved to form the internal step clock.
// R2 - Supplier keeps external clock below 100 kHz.
// R3 - Single held input steps once after four internal clock pulses.
// R4 - Further steps after 40, 20, 12, 8, then every 4 pulses.
// R5 - Releasing the input restarts the interval sequence.
// R6 - Both inputs high changes nothing.
// R7 - Setting is kept while auxiliary supply stays present.
// R8 - Power-up default is -10 dB bridged, -16 dB single-ended.
// R9 - Controller drives raise and lower at full logic levels.
// R10 - Inputs sampled on internal clock; hold counted from first high sample.
// R11 - Step index saturates at maximum and minimum.
`timescale 1ns/100ps
`default_nettype none
`include "volume_step_defines.vh"
module volume_step_repeat_control #(
	parameter integer STEP_W = `VOL_STEP_W
) (
	input wire clk, // 10 MHz system clock
	input wire rst_n, // power-up reset, active low
	input wire ext_clk_sel, // 1: use external clock, 0: internal oscillator
	input wire ext_clk_in, // external clock level
	input wire osc_tick, // internal oscillator pulse, one clk wide
	input wire aux_present, // auxiliary supply present
	input wire main_present, // main supply present
	input wire bridged_load_mode, // 1: bridged, 0: single-ended
	input wire vol_up, // raise request level
	input wire vol_down, // lower request level
	output reg [STEP_W-1:0] vol_step, // current attenuator step index
	output reg step_pulse // one clk pulse per volume step
);
	// Phases of the repeat sequence; the last one repeats for as long as the input is held.
	localparam [2:0] PH_FIRST = 3'd0;
	localparam [2:0] PH_REP1 = 3'd1;
	localparam [2:0] PH_REP2 = 3'd2;
	localparam [2:0] PH_REP3 = 3'd3;
	localparam [2:0] PH_REP4 = 3'd4;
	localparam [2:0] PH_STEADY = 3'd5;

	reg ext_q;
	reg [2:0] phase_q;
	reg [2:0] phase_d;
	reg [7:0] hold_q;
	reg [7:0] hold_d;
	reg dir_q;
	reg dir_d;
	reg active_q;
	reg active_d;
	reg loaded_q;
	reg loaded_d;
	reg [STEP_W-1:0] step_d;
	reg pulse_d;
	wire ext_rise;
	wire ext_tick;
	wire vclk;
	wire up_only;
	wire dn_only;
	wire req;
	wire dir_flip;
	wire interval_done;
	wire at_top;
	wire at_bottom;
	wire [STEP_W-1:0] def_step;

	function [7:0] interval;
		input [2:0] ph;
		begin
			case (ph)
				PH_FIRST: interval = `VOL_FIRST_HOLD;
				PH_REP1: interval = `VOL_REP1;
				PH_REP2: interval = `VOL_REP2;
				PH_REP3: interval = `VOL_REP3;
				PH_REP4: interval = `VOL_REP4;
				default: interval = `VOL_REP_LAST;
			endcase
		end
	endfunction

	// The external clock level is registered once so that each of its rising edges
	// yields exactly one enable pulse, however long the level stays high.
	always @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			ext_q <= 1'b0;
		end else begin
			ext_q <= ext_clk_in;
		end
	end

	assign ext_rise = ext_clk_in & ~ext_q;

	tick_divider #(.DIV(`VOL_EXT_DIV)) u_div ( // R1
		.clk(clk),
		.rst_n(rst_n),
		.en_in(ext_rise),
		.tick(ext_tick)
	);

	// Switching the source while a key is held may give one irregular interval.
	// That is accepted: the source is a board strap, not a run-time control.
	assign vclk = ext_clk_sel ? ext_tick : osc_tick;

	assign up_only = vol_up & ~vol_down;
	assign dn_only = vol_down & ~vol_up;
	assign req = up_only | dn_only; // R6

	// A change of direction without a release counts as a release, so a
	// reversed key never inherits the fast rate of the other one.
	assign dir_flip = active_q & (dir_q != up_only);

	assign interval_done = (hold_q + 8'h01) >= interval(phase_q); // R3 R4 R10
	assign at_top = (vol_step == `VOL_STEP_MAX);
	assign at_bottom = (vol_step == `VOL_STEP_MIN);
	assign def_step = bridged_load_mode ? `VOL_DEF_BRIDGED : `VOL_DEF_SINGLE;

	always @* begin
		loaded_d = 1'b1;
		phase_d = phase_q;
		hold_d = hold_q;
		dir_d = dir_q;
		active_d = active_q;
		step_d = vol_step;
		pulse_d = 1'b0;
		// The default is taken after release so the mode pin is a live level, not a reset value.
		if (!loaded_q) begin
			step_d = def_step; // R8
		end else if (!main_present && !aux_present) begin
			// Nothing moves: the next power-up reset reloads the default.
			step_d = vol_step;
		end else if (!main_present) begin
			phase_d = PH_FIRST; // R7
			hold_d = 8'h00;
			active_d = 1'b0;
		end else if (vclk) begin
			if (!req || dir_flip) begin
				phase_d = PH_FIRST; // R5
				hold_d = 8'h00;
				active_d = 1'b0;
			end else if (interval_done) begin
				hold_d = 8'h00;
				active_d = 1'b1;
				dir_d = up_only;
				if (phase_q != PH_STEADY) begin
					phase_d = phase_q + 3'd1;
				end
				// At either end the sequence still advances, but no pulse is given,
				// so a listener never sees a step that did not change the level.
				if (up_only && !at_top) begin // R11
					step_d = vol_step + 1'b1;
					pulse_d = 1'b1;
				end else if (dn_only && !at_bottom) begin // R11
					step_d = vol_step - 1'b1;
					pulse_d = 1'b1;
				end
			end else begin
				hold_d = hold_q + 8'h01;
				active_d = 1'b1;
				dir_d = up_only;
			end
		end
	end

	// Sequence state.
	always @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			phase_q <= PH_FIRST;
			hold_q <= 8'h00;
			dir_q <= 1'b0;
			active_q <= 1'b0;
			loaded_q <= 1'b0;
		end else begin
			phase_q <= phase_d;
			hold_q <= hold_d;
			dir_q <= dir_d;
			active_q <= active_d;
			loaded_q <= loaded_d;
		end
	end

	// Outputs come straight from flip-flops so the attenuator never sees a glitch.
	always @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			vol_step <= {STEP_W{1'b0}};
			step_pulse <= 1'b0;
		end else begin
			vol_step <= step_d;
			step_pulse <= pulse_d;
		end
	end

endmodule // volume_step_repeat_control
`default_nettype wire
